// >>> design/sllta_pkg.sv
`default_nettype none
package sllta_pkg;
  localparam int FRM_OCT = 2;
  localparam int MF_FRM = 16;
  localparam int ILAS_MF = 4;
  localparam int MB_BLK = 32;
  localparam int EXT_E = 1;
  localparam int CGS_CNT = 4;
  localparam int ERR_MAX = 2;
  localparam int BUF_W = 64;
  localparam int BUF_D = 2;
  localparam logic [7:0] OCT_LAST = 8'(FRM_OCT - 1);
  localparam logic [7:0] FRM_LAST = 8'(MF_FRM - 1);
  localparam logic [4:0] BLK_LAST = 5'(MB_BLK - 1);
  localparam logic [1:0] MF_LAST = 2'(ILAS_MF - 1);
  localparam logic [1:0] MF_CFG = 2'h1;
  localparam logic [7:0] CFG_LAST = 8'h03;
  localparam logic [1:0] CGS_LAST = 2'(CGS_CNT - 1);
  localparam logic [1:0] ERR_LAST = 2'(ERR_MAX - 1);
  localparam logic [7:0] K_R = 8'h1c;
  localparam logic [7:0] K_A = 8'h7c;
  localparam logic [7:0] K_K = 8'hbc;
  localparam logic [7:0] K_F = 8'hfc;
  localparam logic [7:0] OCT_F = K_F;
  localparam logic [7:0] OCT_A = K_A;
  // vector bit 0 is header bit 0
  localparam logic [1:0] SH_ONE = 2'h2;
  localparam logic [1:0] SH_ZERO = 2'h1;
  // stream bits 27..31 read 0,0,0,0,1
  localparam logic [4:0] EOMB_PAT = 5'h10;
  localparam logic [11:0] CRC_POLY = 12'h30f;
  localparam logic [14:0] SCR8_SEED = 15'h7fff;
  localparam logic [57:0] SCR66_SEED = 58'h3ffffffffffffff;

  typedef enum logic [1:0] {TX_CGS, TX_WAIT, TX_ILAS, TX_DATA} sllta_tx_st_t;
  typedef enum logic [2:0] {
    RX_IDLE, RX_CGS, RX_HOLD, RX_ILAS, RX_DATA
  } sllta_rx_st_t;

  function automatic logic [22:0] scr8(input logic [14:0] s,
                                       input logic [7:0] d,
                                       input logic de);
    logic [14:0] st;
    logic [7:0]  o;
    st = s;
    o = 8'h0;
    for (int i = 7; i >= 0; i--) begin
      o[i] = d[i] ^ st[13] ^ st[14];
      st = {st[13:0], de ? d[i] : o[i]};
    end
    return {st, o};
  endfunction

  function automatic logic [121:0] scr66(input logic [57:0] s,
                                         input logic [63:0] d,
                                         input logic de);
    logic [57:0] st;
    logic [63:0] o;
    st = s;
    o = 64'h0;
    for (int i = 63; i >= 0; i--) begin
      o[i] = d[i] ^ st[38] ^ st[57];
      st = {st[56:0], de ? d[i] : o[i]};
    end
    return {st, o};
  endfunction

  function automatic logic [11:0] crc12(input logic [11:0] s,
                                        input logic [63:0] d);
    logic [11:0] c;
    logic        fb;
    c = s;
    for (int i = 63; i >= 0; i--) begin
      fb = c[11] ^ d[i];
      c = {c[10:0], 1'b0} ^ (fb ? CRC_POLY : 12'h0);
    end
    return c;
  endfunction

  // bit b of the result is carried by block b
  function automatic logic [31:0] sync_stream(input logic [11:0] c,
                                              input logic e);
    return {1'b1, 4'h0, 3'h0, 1'b1, e, 1'b1, 1'b0, 1'b1, 3'h0,
            1'b1, c[0], c[1], c[2], 1'b1, c[3], c[4], c[5],
            1'b1, c[6], c[7], c[8], 1'b1, c[9], c[10], c[11]};
  endfunction
endpackage
`default_nettype wire

// >>> design/sllta_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sllta_if;
  logic        sync_n;
  logic        ready;
  logic        valid;
  logic        k;
  logic [7:0]  oct;
  logic [65:0] blk;
  modport tx (output valid, k, oct, blk, input sync_n, ready);
  modport rx (input valid, k, oct, blk, output sync_n, ready);
endinterface
`default_nettype wire

// >>> design/sllta_buf.sv
`timescale 1ns/1ps
`default_nettype none
module sllta_buf
  import sllta_pkg::*;
#(
  parameter int W = BUF_W,
  parameter int D = BUF_D
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_reset_n,
  input  wire logic [W-1:0] i_data,
  input  wire logic         i_valid,
  output logic              o_in_ready,
  output logic [W-1:0]      o_data,
  output logic              o_valid,
  input  wire logic         i_ready
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem_reg [D];
  logic [AW-1:0] wp_reg, rp_reg;
  logic [AW:0]   cnt_reg, cnt_next;
  logic          push, pop;

  assign push = i_valid && o_in_ready;
  assign pop = o_valid && i_ready;
  assign o_valid = cnt_reg != '0;
  assign o_data = mem_reg[rp_reg];
  assign cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_reg[wp_reg] <= i_data;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      o_in_ready <= 1'b0;
    end else begin
      if (push) begin
        wp_reg <= (wp_reg == AW'(D - 1)) ? '0 : wp_reg + AW'(1);
      end
      if (pop) begin
        rp_reg <= (rp_reg == AW'(D - 1)) ? '0 : rp_reg + AW'(1);
      end
      cnt_reg <= cnt_next;
      // ready is registered, so it must fall as the last slot fills
      o_in_ready <= cnt_next != (AW+1)'(D);
    end
  end
endmodule // sllta_buf
`default_nettype wire

// >>> design/sllta_tx.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - receiver pulls sync low once ready
// - commas on every lane while sync low
// - receiver locks after four consecutive commas
// - receiver raises sync at next multiframe edge
// - sync rise: wait multiframe edge, start alignment
// - four alignment multiframes, R first, A last
// - receiver buffers from R, releases together; here buffering starts only after the last A
// - repeated frame-final octet sent as F
// - at multiframe end use A instead
// - receiver checks placement, restores previous octet
// - scrambled: 0xFC as F, 0x7C as A
// - scrambled receiver maps F, A back
// - receiver resyncs on repeated misplacement errors; here it drops to idle and searches again only after a fresh sysref
// - pack eight octets, scramble, add header
// - header bits 0-1, octets follow in order
// - thirty-two blocks per multiblock, E one
// - sysref resets extended multiblock clock phase
// - header is 01 or 10 only
// - receiver treats 00 or 11 as misalignment
// - header stream ends with 00001 pilot
// - stream bit 22 marks last multiblock
// - stream carries CRC-12 parity, no command
// - scrambling always in 66 mode, optional else
module sllta_tx
  import sllta_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset_n,
  input  wire logic        i_sysref,
  input  wire logic        i_mode_66,
  input  wire logic        i_scramble_enable_bit,
  input  wire logic [63:0] i_data,
  input  wire logic        i_valid,
  output logic             o_ready,
  output logic             o_link_up,
  sllta_if.tx              lnk
);
  sllta_tx_st_t  st_reg;
  logic          sr_meta_reg, sr_sync_reg, sr_prev_reg, sr_rise;
  logic          sy_prev_reg, sy_rise;
  logic [7:0]    oct_cnt_reg, frm_cnt_reg, pos;
  logic [4:0]    blk_cnt_reg;
  logic [1:0]    mf_cnt_reg;
  logic          eof, eomf, adv, need, take, lmfc_edge;
  logic [63:0]   bd;
  logic          bv;
  logic [14:0]   s8_reg, s8_next;
  logic [57:0]   s66_reg, s66_next;
  logic [22:0]   r8;
  logic [121:0]  r66;
  logic [11:0]   crc_acc_reg, crc_sent_reg, crc_next;
  logic [31:0]   shs;
  logic [7:0]    last_reg, d8, sc8, oct_next;
  logic          k_next;
  logic [65:0]   blk_next;
  logic          lv_reg, k_reg;
  logic [7:0]    oct_reg;
  logic [65:0]   blk_reg;

  sllta_buf u_buf (
    .i_clk_sys  (i_clk_sys),
    .i_reset_n  (i_reset_n),
    .i_data     (i_data),
    .i_valid    (i_valid),
    .o_in_ready (o_ready),
    .o_data     (bd),
    .o_valid    (bv),
    .i_ready    (adv && need)
  );

  assign lnk.valid = lv_reg;
  assign lnk.k = k_reg;
  assign lnk.oct = oct_reg;
  assign lnk.blk = blk_reg;

  assign sr_rise = sr_sync_reg & ~sr_prev_reg;
  assign sy_rise = lnk.sync_n & ~sy_prev_reg;
  assign eof = oct_cnt_reg == OCT_LAST;
  assign eomf = eof && (frm_cnt_reg == FRM_LAST);
  // the output stage moves when it is empty or when the receiver takes the symbol
  assign adv = ~lv_reg | lnk.ready;
  assign need = i_mode_66 || (st_reg == TX_DATA);
  assign take = adv && (~need || bv);
  assign lmfc_edge = take && eomf;
  // E fixed at one: every multiblock closes an extended multiblock
  assign shs = sync_stream(crc_sent_reg, 1'b1);

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sr_meta_reg <= 1'b0;
      sr_sync_reg <= 1'b0;
      sr_prev_reg <= 1'b0;
      sy_prev_reg <= 1'b1;
    end else begin
      sr_meta_reg <= i_sysref;
      sr_sync_reg <= sr_meta_reg;
      sr_prev_reg <= sr_sync_reg;
      sy_prev_reg <= lnk.sync_n;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      oct_cnt_reg <= 8'h0;
      frm_cnt_reg <= 8'h0;
      blk_cnt_reg <= 5'h0;
    end else if (sr_rise) begin
      oct_cnt_reg <= 8'h0;
      frm_cnt_reg <= 8'h0;
      blk_cnt_reg <= 5'h0;
    end else if (take) begin
      if (i_mode_66) begin
        blk_cnt_reg <= (blk_cnt_reg == BLK_LAST) ? 5'h0 : blk_cnt_reg + 5'h1;
      end else if (eof) begin
        oct_cnt_reg <= 8'h0;
        frm_cnt_reg <= eomf ? 8'h0 : frm_cnt_reg + 8'h1;
      end else begin
        oct_cnt_reg <= oct_cnt_reg + 8'h1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_reg <= TX_CGS;
    end else if (~lnk.sync_n) begin
      st_reg <= TX_CGS;
    end else begin
      unique case (st_reg)
        TX_CGS: begin
          if (sy_rise) begin
            st_reg <= TX_WAIT;
          end
        end
        TX_WAIT: begin
          if (lmfc_edge) begin
            st_reg <= TX_ILAS;
          end
        end
        TX_ILAS: begin
          if (lmfc_edge && mf_cnt_reg == MF_LAST) begin
            st_reg <= TX_DATA;
          end
        end
        TX_DATA: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mf_cnt_reg <= 2'h0;
    end else if (st_reg != TX_ILAS) begin
      mf_cnt_reg <= 2'h0;
    end else if (lmfc_edge) begin
      mf_cnt_reg <= mf_cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s8_reg <= SCR8_SEED;
      s66_reg <= SCR66_SEED;
      last_reg <= 8'h0;
    end else begin
      if (take) begin
        s8_reg <= s8_next;
        s66_reg <= s66_next;
      end
      // both ends clear the compare octet before data starts
      if (st_reg != TX_DATA) begin
        last_reg <= 8'h0;
      end else if (take && eof && !i_mode_66) begin
        last_reg <= d8;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      crc_acc_reg <= 12'h0;
      crc_sent_reg <= 12'h0;
    end else if (take && i_mode_66) begin
      // parity of one multiblock rides in the next one
      if (blk_cnt_reg == BLK_LAST) begin
        crc_sent_reg <= crc_next;
        crc_acc_reg <= 12'h0;
      end else begin
        crc_acc_reg <= crc_next;
      end
    end
  end

  always_comb begin
    pos = 8'(int'(frm_cnt_reg) * FRM_OCT + int'(oct_cnt_reg));
    d8 = bd[7:0];
    r8 = scr8(s8_reg, d8, 1'b0);
    r66 = scr66(s66_reg, bd, 1'b0);
    crc_next = crc12(crc_acc_reg, r66[63:0]);
    sc8 = i_scramble_enable_bit ? r8[7:0] : d8;
    s8_next = s8_reg;
    s66_next = s66_reg;
    k_next = 1'b1;
    oct_next = K_K;
    blk_next = {r66[63:0], shs[blk_cnt_reg] ? SH_ONE : SH_ZERO};
    if (i_mode_66) begin
      s66_next = r66[121:64];
    end else begin
      unique case (st_reg)
        TX_CGS, TX_WAIT: begin
        end
        TX_ILAS: begin
          // alignment multiframes are never scrambled
          k_next = 1'b0;
          oct_next = pos;
          if (pos == 8'h0) begin
            k_next = 1'b1;
            oct_next = K_R;
          end else if (eomf) begin
            k_next = 1'b1;
            oct_next = K_A;
          end else if (mf_cnt_reg == MF_CFG && pos <= CFG_LAST) begin
            unique case (pos)
              8'h1: oct_next = OCT_LAST;
              8'h2: oct_next = FRM_LAST;
              default: oct_next = {7'h0, i_scramble_enable_bit};
            endcase
          end
        end
        TX_DATA: begin
          k_next = 1'b0;
          oct_next = sc8;
          if (i_scramble_enable_bit) begin
            s8_next = r8[22:8];
            if (eof && sc8 == OCT_F) begin
              k_next = 1'b1;
              oct_next = K_F;
            end else if (eomf && sc8 == OCT_A) begin
              k_next = 1'b1;
              oct_next = K_A;
            end
          end else if (eof && d8 == last_reg) begin
            k_next = 1'b1;
            oct_next = eomf ? K_A : K_F;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lv_reg <= 1'b0;
      k_reg <= 1'b1;
      oct_reg <= K_K;
      blk_reg <= 66'h0;
      o_link_up <= 1'b0;
    end else begin
      if (adv) begin
        lv_reg <= take;
      end
      if (take) begin
        k_reg <= k_next;
        oct_reg <= oct_next;
        blk_reg <= blk_next;
      end
      o_link_up <= i_mode_66 || (st_reg == TX_DATA);
    end
  end
endmodule // sllta_tx
`default_nettype wire

// >>> design/sllta_rx.sv
`timescale 1ns/1ps
`default_nettype none
module sllta_rx
  import sllta_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset_n,
  input  wire logic        i_sysref,
  input  wire logic        i_mode_66,
  input  wire logic        i_scramble_enable_bit,
  output logic [63:0]      o_data,
  output logic             o_valid,
  input  wire logic        i_ready,
  output logic             o_link_up,
  output logic             o_align_err,
  sllta_if.rx              lnk
);
  sllta_rx_st_t st_reg;
  logic         sr_meta_reg, sr_sync_reg, sr_prev_reg, sr_rise, sr_seen_reg;
  logic [7:0]   oct_cnt_reg, frm_cnt_reg, oc, fc, last_reg, rest, d8;
  logic [4:0]   blk_cnt_reg;
  logic [1:0]   cgs_cnt_reg, mf_cnt_reg, err_cnt_reg;
  logic [14:0]  s8_reg;
  logic [57:0]  s66_reg;
  logic [31:0]  shs_reg, shs;
  logic [22:0]  r8;
  logic [121:0] r66;
  logic         sync_n_reg, ilas_on_reg, brdy, acc, rl, eof, eomf;
  logic         comma, ok_pos, err_now, err_lim, wr;

  sllta_buf u_buf (
    .i_clk_sys  (i_clk_sys),
    .i_reset_n  (i_reset_n),
    .i_data     (i_mode_66 ? r66[63:0] : {56'h0, d8}),
    .i_valid    (wr),
    .o_in_ready (brdy),
    .o_data     (o_data),
    .o_valid    (o_valid),
    .i_ready    (i_ready)
  );

  assign lnk.ready = brdy;
  assign lnk.sync_n = sync_n_reg;
  assign acc = lnk.valid && brdy;
  assign sr_rise = sr_sync_reg & ~sr_prev_reg;
  assign comma = lnk.k && lnk.oct == K_K;
  assign rl = st_reg == RX_ILAS && lnk.k && lnk.oct == K_R;
  assign oc = rl ? 8'h0 : oct_cnt_reg;
  assign fc = rl ? 8'h0 : frm_cnt_reg;
  assign eof = oc == OCT_LAST;
  assign eomf = eof && fc == FRM_LAST;
  assign ok_pos = (lnk.oct == K_F && eof) || (lnk.oct == K_A && eomf);
  assign rest = !lnk.k ? lnk.oct : !i_scramble_enable_bit ? last_reg :
                lnk.oct == K_F ? OCT_F : OCT_A;
  assign r8 = scr8(s8_reg, rest, 1'b1);
  assign d8 = i_scramble_enable_bit ? r8[7:0] : rest;
  assign r66 = scr66(s66_reg, lnk.blk[65:2], 1'b1);
  assign shs = {lnk.blk[1:0] == SH_ONE, shs_reg[31:1]};
  // outside 66 mode, lanes are released only once the whole alignment run is seen
  assign wr = acc && (i_mode_66 || st_reg == RX_DATA);
  assign err_now = acc && (i_mode_66 ?
    (lnk.blk[0] == lnk.blk[1] ||
     (blk_cnt_reg == BLK_LAST && shs[31:27] != EOMB_PAT)) :
    (st_reg == RX_DATA && lnk.k && !ok_pos));
  assign err_lim = err_now && err_cnt_reg == ERR_LAST;

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sr_meta_reg <= 1'b0;
      sr_sync_reg <= 1'b0;
      sr_prev_reg <= 1'b0;
      sr_seen_reg <= 1'b0;
    end else begin
      sr_meta_reg <= i_sysref;
      sr_sync_reg <= sr_meta_reg;
      sr_prev_reg <= sr_sync_reg;
      // a fresh sysref is demanded before any new search
      if (sr_rise) begin
        sr_seen_reg <= 1'b1;
      end else if (err_lim) begin
        sr_seen_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      oct_cnt_reg <= 8'h0;
      frm_cnt_reg <= 8'h0;
      blk_cnt_reg <= 5'h0;
    end else if (sr_rise) begin
      oct_cnt_reg <= 8'h0;
      frm_cnt_reg <= 8'h0;
      blk_cnt_reg <= 5'h0;
    end else if (acc) begin
      blk_cnt_reg <= (blk_cnt_reg == BLK_LAST) ? 5'h0 : blk_cnt_reg + 5'h1;
      oct_cnt_reg <= eof ? 8'h0 : oc + 8'h1;
      frm_cnt_reg <= eomf ? 8'h0 : eof ? fc + 8'h1 : fc;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_reg <= RX_IDLE;
    end else if (err_lim) begin
      st_reg <= RX_IDLE;
    end else begin
      unique case (st_reg)
        RX_IDLE: begin
          if (sr_seen_reg && !i_mode_66) begin
            st_reg <= RX_CGS;
          end
        end
        RX_CGS: begin
          if (acc && comma && cgs_cnt_reg == CGS_LAST) begin
            st_reg <= RX_HOLD;
          end
        end
        RX_HOLD: begin
          if (acc && eomf) begin
            st_reg <= RX_ILAS;
          end
        end
        RX_ILAS: begin
          if (acc && ilas_on_reg && lnk.k && lnk.oct == K_A &&
              mf_cnt_reg == MF_LAST) begin
            st_reg <= RX_DATA;
          end
        end
        RX_DATA: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cgs_cnt_reg <= 2'h0;
      mf_cnt_reg <= 2'h0;
      ilas_on_reg <= 1'b0;
      err_cnt_reg <= 2'h0;
      sync_n_reg <= 1'b1;
    end else begin
      if (st_reg != RX_CGS) begin
        cgs_cnt_reg <= 2'h0;
      end else if (acc) begin
        cgs_cnt_reg <= comma ? cgs_cnt_reg + 2'h1 : 2'h0;
      end
      if (st_reg != RX_ILAS) begin
        ilas_on_reg <= 1'b0;
        mf_cnt_reg <= 2'h0;
      end else if (acc && rl) begin
        ilas_on_reg <= 1'b1;
      end else if (acc && ilas_on_reg && lnk.k && lnk.oct == K_A) begin
        mf_cnt_reg <= mf_cnt_reg + 2'h1;
      end
      if (err_lim || st_reg == RX_CGS) begin
        err_cnt_reg <= 2'h0;
      end else if (err_now) begin
        err_cnt_reg <= err_cnt_reg + 2'h1;
      end
      sync_n_reg <= !(st_reg == RX_CGS || st_reg == RX_HOLD);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s8_reg <= SCR8_SEED;
      s66_reg <= SCR66_SEED;
      shs_reg <= 32'h0;
      last_reg <= 8'h0;
      o_link_up <= 1'b0;
      o_align_err <= 1'b0;
    end else begin
      if (acc && i_mode_66) begin
        s66_reg <= r66[121:64];
        shs_reg <= shs;
      end
      if (wr && !i_mode_66 && i_scramble_enable_bit) begin
        s8_reg <= r8[22:8];
      end
      if (st_reg != RX_DATA) begin
        last_reg <= 8'h0;
      end else if (wr && eof) begin
        last_reg <= rest;
      end
      o_link_up <= i_mode_66 ? sr_seen_reg : st_reg == RX_DATA;
      o_align_err <= err_now;
    end
  end
endmodule // sllta_rx
`default_nettype wire

// >>> test/sllta_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sllta_link_checker
  import sllta_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset_n,
  input  wire logic        i_mode_66,
  input  wire logic        sync_n,
  input  wire logic        ready,
  input  wire logic        valid,
  input  wire logic        k,
  input  wire logic [7:0]  oct,
  input  wire logic [65:0] blk
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  logic        xfer;
  logic        pilot;
  logic        pil_reg;
  logic [4:0]  pos_reg;
  logic [4:0]  gap_reg;
  logic [31:0] sh_reg;
  logic [31:0] sh_next;
  assign xfer = valid && ready;
  // header 01 conveys a one and puts it in vector bit 1
  assign sh_next = {sh_reg[30:0], blk[1]};
  assign pilot = i_mode_66 && xfer && sh_next[4:0] == 5'h01;
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pos_reg <= 5'h00;
    end else if (xfer) begin
      // realigned on each multiframe start seen on the wire
      pos_reg <= (k && oct == K_R) ? 5'h01 : pos_reg + 5'h01;
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      // all ones, so a short history never fakes the pilot
      sh_reg  <= 32'hffffffff;
      gap_reg <= 5'h00;
      pil_reg <= 1'b0;
    end else if (xfer) begin
      sh_reg  <= sh_next;
      gap_reg <= pilot ? 5'h00 : gap_reg + 5'h01;
      pil_reg <= pil_reg || pilot;
    end
  end
  a_hdr_never_equal: assert property (i_mode_66 && valid |-> blk[0] != blk[1])
    else $error("header bits equal");
  a_comma_sync_low: assert property ((!i_mode_66 && !sync_n) [*3] |-> !valid || (k && oct == K_K))
    else $error("no comma while sync low");
  a_commas_till_r: assert property ($rose(sync_n) && !i_mode_66 |-> (!valid || (k && oct == K_K)) until (valid && k && oct == K_R))
    else $error("data before alignment start");
  a_r_in_time: assert property ($rose(sync_n) && !i_mode_66 |-> ##[1:80] (valid && k && oct == K_R))
    else $error("alignment start late");
  a_a_at_mf_end: assert property (!i_mode_66 && xfer && k && oct == K_A |-> pos_reg == 5'h1f)
    else $error("multiframe mark misplaced");
  a_f_at_frm_end: assert property (!i_mode_66 && xfer && k && oct == K_F |-> pos_reg[0])
    else $error("frame mark misplaced");
  a_link_word_holds: assert property (valid && !ready |=> valid && $stable(k) && $stable(oct) && $stable(blk))
    else $error("stalled word changed");
  a_pilot_period: assert property (pilot && pil_reg |-> gap_reg == 5'h1f)
    else $error("multiblock length wrong");
  a_pilot_fields: assert property (pilot && pil_reg |-> sh_next[9] && sh_next[28] && sh_next[24] && sh_next[20] && sh_next[16] && sh_next[12] && sh_next[10] && sh_next[8])
    else $error("stream fixed bits wrong");
endmodule // sllta_link_checker
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import sllta_pkg::*;
;
  typedef struct {
    logic        m66;
    logic        scramble_enable_bit;
    logic [63:0] d;
    logic [63:0] exp;
  } sllta_row_t;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        m66 = 1'b0;
  logic        scramble_enable_bit = 1'b0;
  logic        sys_tx = 1'b0;
  logic        sys_rx = 1'b0;
  logic        tx_vld = 1'b0;
  logic        rx_rdy = 1'b1;
  logic        track = 1'b0;
  logic        stall = 1'b0;
  logic [63:0] tx_d = 64'h0;
  logic [63:0] rx_d;
  logic        tx_rdy, tx_up, rx_vld, rx_up, rx_err;
  int          failures = 0;
  int          samples_checked = 0;
  int          errs = 0;
  int          cyc = 0;
  logic [63:0] exp_q[$];
  sllta_row_t  rows[128];
  sllta_if lnk ();
  sllta_tx sllta_tx_inst (.i_clk_sys(clk), .i_reset_n(rst_n),
    .i_sysref(sys_tx), .i_mode_66(m66), .i_scramble_enable_bit(scramble_enable_bit),
    .i_data(tx_d), .i_valid(tx_vld), .o_ready(tx_rdy), .o_link_up(tx_up),
    .lnk(lnk.tx));
  sllta_rx sllta_rx_inst (.i_clk_sys(clk), .i_reset_n(rst_n),
    .i_sysref(sys_rx), .i_mode_66(m66), .i_scramble_enable_bit(scramble_enable_bit),
    .o_data(rx_d), .o_valid(rx_vld), .i_ready(rx_rdy), .o_link_up(rx_up),
    .o_align_err(rx_err), .lnk(lnk.rx));
  sllta_link_checker sllta_link_checker_inst (.i_clk_sys(clk),
    .i_reset_n(rst_n), .i_mode_66(m66), .sync_n(lnk.sync_n),
    .ready(lnk.ready), .valid(lnk.valid), .k(lnk.k), .oct(lnk.oct),
    .blk(lnk.blk));
  always #10 clk = ~clk;
  task automatic check(input string nm, input logic [63:0] seen,
                       input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (failures == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic pulse(input logic [1:0] sel);
    @(posedge clk);
    #1 {sys_tx, sys_rx} = sel;
    repeat (4) @(posedge clk);
    #1 {sys_tx, sys_rx} = 2'h0;
  endtask
  task automatic wait_up();
    int n;
    n = 0;
    while (!(tx_up === 1'b1 && rx_up === 1'b1) && n < 3000) begin
      @(posedge clk);
      n++;
    end
    #1 check("link up", 64'({tx_up, rx_up}), 64'h3);
    track = 1'b1;
  endtask
  task automatic up(input logic a66, input logic s);
    rst_n = 1'b0;
    m66 = a66;
    scramble_enable_bit = s;
    track = 1'b0;
    stall = a66;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    pulse(2'h3);
    wait_up();
  endtask
  // valid stays up between calls so words go back to back
  task automatic put(input logic [63:0] d, input logic [63:0] e);
    int n;
    n = 0;
    tx_d = d;
    tx_vld = 1'b1;
    // ready is read while it stands, before the edge that takes the word
    while (tx_rdy !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1 n++;
    end
    @(posedge clk);
    if (track) exp_q.push_back(e);
    #1;
  endtask
  task automatic drain();
    int n;
    n = 0;
    tx_vld = 1'b0;
    while (exp_q.size() != 0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    #1 check("words left", 64'(exp_q.size()), 64'h0);
  endtask
  // in 66 mode the receiver user stalls in bursts to push back across the link
  always @(posedge clk) begin
    cyc = cyc + 1;
    #1 rx_rdy = !(stall && cyc % 8 > 5);
  end
  always @(posedge clk) begin
    if (rx_err === 1'b1) errs++;
    if (rx_vld === 1'b1 && rx_rdy && track) begin
      if (exp_q.size() == 0) check("spare word", 64'h1, 64'h0);
      else check("rx word", rx_d, exp_q.pop_front());
    end
  end
  initial begin
    #(20 * 60000);
    failures++;
    print_verdict();
  end
  initial begin
    int n;
    for (int i = 0; i < 128; i++) begin
      rows[i].m66 = (i >= 64);
      rows[i].scramble_enable_bit = (i / 32 == 1);
      // runs of equal octets force frame-end substitution
      if (i < 32) rows[i].d = (i % 8 < 4 || i > 27) ? 64'h5a : 64'(i);
      else if (i < 64) rows[i].d = (i % 2 != 0) ? 64'hfc : 64'h7c;
      else rows[i].d = {8{8'(i * 37)}};
      rows[i].exp = rows[i].m66 ? rows[i].d : {56'h0, rows[i].d[7:0]};
    end
    // two multiblocks in 66 mode, so the second carries real parity
    for (int i = 0; i < 128; i++) begin
      if (i % 32 == 0 && i <= 64) begin
        if (i != 0) drain();
        up(rows[i].m66, rows[i].scramble_enable_bit);
      end
      put(rows[i].d, rows[i].exp);
    end
    drain();
    check("no align err", 64'(errs), 64'h0);
    rst_n = 1'b0;
    @(posedge clk);
    #1 check("reset outs", 64'({lnk.sync_n, lnk.valid, lnk.k,
             lnk.oct, tx_rdy, tx_up, rx_up, rx_vld}), 64'({3'h5, K_K, 4'h0}));
    up(1'b0, 1'b0);
    track = 1'b0;
    // receiver timing moved alone, so marks land off its boundaries
    for (int i = 0; i < 120; i++) begin
      if (i == 16) pulse(2'h1);
      put(64'h5a, 64'h0);
    end
    tx_vld = 1'b0;
    check("align err", 64'(errs != 0), 64'h1);
    pulse(2'h3);
    n = 0;
    while (tx_up !== 1'b0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    #1 check("tx drops", 64'(tx_up), 64'h0);
    wait_up();
    print_verdict();
  end
endmodule // tb
`default_nettype wire
